// [pkg/bwl_pkg.sv]
// constants and types for the broadcast write and soft load register bank
package bwl_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_SLD_EN     = 8'hd1;
  localparam logic [7:0] IDX_DAC_CH0    = 8'hd2;
  localparam logic [7:0] IDX_DAC_CH7    = 8'he0;
  localparam logic [7:0] IDX_DAC_BVAL   = 8'he2;
  localparam logic [7:0] IDX_DAC_SEL    = 8'he4;
  localparam logic [7:0] IDX_TRIG       = 8'he5;
  localparam logic [7:0] IDX_IN_BVAL    = 8'he6;
  localparam logic [7:0] IDX_IN_SEL     = 8'he8;
  localparam logic [7:0] IDX_HOLD_CH0   = 8'hc0;
  localparam logic [7:0] IDX_HOLD_CH7   = 8'hce;

  // address slicing of the bus byte address
  localparam int IDX_LSB = 2;
  localparam int IDX_W   = 8;

  // field positions
  localparam int TRIG_BIT = 7;

  // reset values
  localparam logic [7:0]  DAC_SEL_RST = 8'hff;
  localparam logic [7:0]  IN_SEL_RST  = 8'hff;
  localparam logic [7:0]  SLD_EN_RST  = 8'hff;
  localparam logic [7:0]  TRIG_RST    = 8'h00;
  localparam logic [15:0] BVAL_RST    = 16'h0000;
  localparam logic [15:0] CODE_RST    = 16'h0000;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} bwl_rd_st_t;

  typedef enum logic [3:0] {
    K_NONE, K_SLD_EN, K_DAC_CH, K_HOLD_CH, K_DAC_BVAL,
    K_DAC_SEL, K_TRIG, K_IN_BVAL, K_IN_SEL
  } bwl_kind_t;

endpackage

// [design/bwl_chan_bank.sv]
// holding and active code registers of the eight channels
`timescale 1ns/10ps
module bwl_chan_bank
  import bwl_pkg::*;
#(
  parameter int NCH = 8,
  parameter int DW  = 16
)
(
  input  wire logic                MCLK,
  input  wire logic                SYS_RST,
  input  wire logic [NCH-1:0]      HOLD_WE,
  input  wire logic [1:0]          HOLD_BE,
  input  wire logic [DW-1:0]       HOLD_WDATA,
  input  wire logic [NCH-1:0]      ACT_WE,
  input  wire logic [1:0]          ACT_BE,
  input  wire logic [DW-1:0]       ACT_WDATA,
  input  wire logic [NCH-1:0]      LOAD_MASK,
  input  wire logic                RD_ACTIVE,
  input  wire logic [2:0]          RD_CH,
  output logic      [DW-1:0]       RD_DATA,
  output logic      [NCH*DW-1:0]   ACTIVE_CODES
);

  typedef struct packed {
    logic [NCH-1:0][DW-1:0] hold;
    logic [NCH-1:0][DW-1:0] act;
    logic [DW-1:0]          rd;
  } bwl_bank_t;

  bwl_bank_t st_ff;
  bwl_bank_t nxt_st;

  // byte-lane merge of a new value into an old one
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
                                          input logic [DW-1:0] new_v,
                                          input logic [1:0]    be);
    logic [DW-1:0] r;
    r = old_v;
    if (be[0])
      r[7:0] = new_v[7:0];
    if (be[1])
      r[DW-1:8] = new_v[DW-1:8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state: a load copies every enabled channel in the same edge
  always_comb
  begin
    nxt_st = st_ff;
    for (int n = 0; n < NCH; n++)
    begin
      if (HOLD_WE[n])
        nxt_st.hold[n] = merge(st_ff.hold[n], HOLD_WDATA, HOLD_BE);
      if (LOAD_MASK[n])
        nxt_st.act[n] = st_ff.hold[n];
      else if (ACT_WE[n])
        nxt_st.act[n] = merge(st_ff.act[n], ACT_WDATA, ACT_BE);
    end
    // read data is registered so the bus sees a flop, one cycle late
    nxt_st.rd = RD_ACTIVE ? st_ff.act[RD_CH] : st_ff.hold[RD_CH];
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_ff.hold <= {NCH{CODE_RST}};
      st_ff.act  <= {NCH{CODE_RST}};
      st_ff.rd   <= CODE_RST;
    end
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////
  assign RD_DATA      = st_ff.rd;
  assign ACTIVE_CODES = st_ff.act;

endmodule

// [design/bwl_regs.sv]
// axi4-lite register bank with broadcast writes and software load
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module bwl_regs
  import bwl_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int NCH    = 8,
  parameter int DW     = 16
)
(
  input  wire logic                MCLK,
  input  wire logic                SYS_RST,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [ADDR_W-1:0]   AWADDR,
  input  wire logic [2:0]          AWPROT,
  input  wire logic                WVALID,
  output logic                     WREADY,
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  output logic                     BVALID,
  input  wire logic                BREADY,
  output logic      [1:0]          BRESP,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  input  wire logic [ADDR_W-1:0]   ARADDR,
  input  wire logic [2:0]          ARPROT,
  output logic                     RVALID,
  input  wire logic                RREADY,
  output logic      [31:0]         RDATA,
  output logic      [1:0]          RRESP,
  output logic      [NCH*DW-1:0]   CHANNEL_ACTIVE_CODE
);

  typedef struct packed {
    bwl_rd_st_t        rd_st;
    logic              aw_ok;
    logic [IDX_W-1:0]  aw_idx;
    logic              w_ok;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic [IDX_W-1:0]  ar_idx;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [NCH-1:0]    dac_sel;
    logic [NCH-1:0]    in_sel;
    logic [NCH-1:0]    sld_en;
    logic [DW-1:0]     dac_bval;
    logic [DW-1:0]     in_bval;
  } bwl_state_t;

  bwl_state_t st_ff;
  bwl_state_t nxt_st;

  logic [NCH-1:0]   hold_we;
  logic [NCH-1:0]   act_we;
  logic [1:0]       act_be;
  logic [DW-1:0]    act_wdata;
  logic [1:0]       hold_be;
  logic [DW-1:0]    hold_wdata;
  logic [NCH-1:0]   load_mask;
  logic             rd_active;
  logic [2:0]       rd_ch;
  logic [DW-1:0]    bank_rd;

  ////////////////////////////////////////////////////////////////////////
  // address decode, used for both the write and the read path
  function automatic bwl_kind_t decode(input logic [IDX_W-1:0] idx);
    bwl_kind_t k;
    k = K_NONE;
    if (idx == IDX_SLD_EN)
      k = K_SLD_EN;
    else if (idx >= IDX_DAC_CH0 && idx <= IDX_DAC_CH7 && !idx[0])
      k = K_DAC_CH;
    else if (idx >= IDX_HOLD_CH0 && idx <= IDX_HOLD_CH7 && !idx[0])
      k = K_HOLD_CH;
    else if (idx == IDX_DAC_BVAL)
      k = K_DAC_BVAL;
    else if (idx == IDX_DAC_SEL)
      k = K_DAC_SEL;
    else if (idx == IDX_TRIG)
      k = K_TRIG;
    else if (idx == IDX_IN_BVAL)
      k = K_IN_BVAL;
    else if (idx == IDX_IN_SEL)
      k = K_IN_SEL;
    return k;
  endfunction

  // channel number of a two-index-wide channel register
  function automatic logic [2:0] chan_of(input logic [IDX_W-1:0] idx,
                                         input logic [IDX_W-1:0] base);
    logic [IDX_W-1:0] d;
    d = idx - base;
    return d[3:1];
  endfunction

  // byte-lane merge for the 16-bit registers held here
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
                                          input logic [31:0]   new_v,
                                          input logic [3:0]    be);
    logic [DW-1:0] r;
    r = old_v;
    if (be[0])
      r[7:0] = new_v[7:0];
    if (be[1])
      r[DW-1:8] = new_v[DW-1:8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes: one write and one read in flight at a time
  assign AWREADY = !st_ff.aw_ok && !st_ff.bvalid;
  assign WREADY  = !st_ff.w_ok && !st_ff.bvalid;
  assign ARREADY = (st_ff.rd_st == RD_IDLE);
  assign BVALID  = st_ff.bvalid;
  assign BRESP   = st_ff.bresp;
  assign RVALID  = (st_ff.rd_st == RD_RESP);
  assign RDATA   = st_ff.rdata;
  assign RRESP   = st_ff.rresp;

  ////////////////////////////////////////////////////////////////////////
  // next state of the bus slave and the control registers
  always_comb
  begin
    logic              aw_go;
    logic              w_go;
    logic              wr_go;
    logic [IDX_W-1:0]  widx;
    logic [31:0]       wd;
    logic [3:0]        ws;
    bwl_kind_t         wk;
    bwl_kind_t         rk;
    logic [DW-1:0]     bval;
    aw_go     = AWVALID && AWREADY;
    w_go      = WVALID && WREADY;
    widx      = st_ff.aw_ok ? st_ff.aw_idx : AWADDR[IDX_LSB +: IDX_W];
    wd        = st_ff.w_ok ? st_ff.wdata : WDATA;
    ws        = st_ff.w_ok ? st_ff.wstrb : WSTRB;
    wr_go     = (st_ff.aw_ok || aw_go) && (st_ff.w_ok || w_go);
    wk        = decode(widx);
    rk        = decode(st_ff.ar_idx);
    bval      = '0;
    nxt_st    = st_ff;
    hold_we   = '0;
    act_we    = '0;
    act_be    = ws[1:0];
    act_wdata = wd[DW-1:0];
    hold_be   = ws[1:0];
    hold_wdata = wd[DW-1:0];
    load_mask = '0;
    rd_active = 1'b0;
    rd_ch     = 3'h0;

    // address and data may come in either order; park whichever is first
    if (aw_go)
    begin
      nxt_st.aw_ok  = 1'b1;
      nxt_st.aw_idx = AWADDR[IDX_LSB +: IDX_W];
    end
    if (w_go)
    begin
      nxt_st.w_ok  = 1'b1;
      nxt_st.wdata = WDATA;
      nxt_st.wstrb = WSTRB;
    end
    if (st_ff.bvalid && BREADY)
      nxt_st.bvalid = 1'b0;

    // write execution, once both halves are present
    if (wr_go)
    begin
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = (wk == K_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (wk)
        K_SLD_EN:
          if (ws[0])
            nxt_st.sld_en = wd[NCH-1:0];
        K_DAC_CH:
          act_we[chan_of(widx, IDX_DAC_CH0)] = 1'b1;
        K_HOLD_CH:
          hold_we[chan_of(widx, IDX_HOLD_CH0)] = 1'b1;
        K_DAC_BVAL:
        begin
          // the merged value is what is kept and what fans out
          bval            = merge(st_ff.dac_bval, wd, ws);
          nxt_st.dac_bval = bval;
          act_be          = 2'h3;
          act_wdata       = bval;
          act_we          = st_ff.dac_sel;
        end
        K_DAC_SEL:
          if (ws[0])
            nxt_st.dac_sel = wd[NCH-1:0];
        K_TRIG:
          // only the trigger lane matters; reserved bits are not stored
          if (ws[0] && wd[TRIG_BIT])
            load_mask = st_ff.sld_en;
        K_IN_BVAL:
        begin
          bval           = merge(st_ff.in_bval, wd, ws);
          nxt_st.in_bval = bval;
          // the merged value fans out whole, every lane of each selected holding code
          hold_be        = 2'h3;
          hold_wdata     = bval;
          hold_we        = st_ff.in_sel;
        end
        K_IN_SEL:
          if (ws[0])
            nxt_st.in_sel = wd[NCH-1:0];
        default:
          nxt_st.bresp = RESP_SLVERR;
      endcase
    end

    // read path: the channel bank read is launched as the address is taken
    case (st_ff.rd_st)
      RD_IDLE:
        if (ARVALID)
        begin
          nxt_st.ar_idx = ARADDR[IDX_LSB +: IDX_W];
          nxt_st.rd_st  = RD_FETCH;
          rd_active = (decode(ARADDR[IDX_LSB +: IDX_W]) == K_DAC_CH);
          rd_ch     = rd_active
                      ? chan_of(ARADDR[IDX_LSB +: IDX_W], IDX_DAC_CH0)
                      : chan_of(ARADDR[IDX_LSB +: IDX_W], IDX_HOLD_CH0);
        end
      RD_FETCH:
      begin
        nxt_st.rd_st = RD_RESP;
        nxt_st.rresp = RESP_OKAY;
        nxt_st.rdata = 32'h0000_0000;
        case (rk)
          K_SLD_EN:   nxt_st.rdata[NCH-1:0] = st_ff.sld_en;
          K_DAC_CH:   nxt_st.rdata[DW-1:0]  = bank_rd;
          K_HOLD_CH:  nxt_st.rdata[DW-1:0]  = bank_rd;
          K_DAC_BVAL: nxt_st.rdata[DW-1:0]  = st_ff.dac_bval;
          K_DAC_SEL:  nxt_st.rdata[NCH-1:0] = st_ff.dac_sel;
          K_TRIG:     nxt_st.rdata = 32'h0000_0000;
          K_IN_BVAL:  nxt_st.rdata[DW-1:0]  = st_ff.in_bval;
          K_IN_SEL:   nxt_st.rdata[NCH-1:0] = st_ff.in_sel;
          default:    nxt_st.rresp = RESP_SLVERR;
        endcase
      end
      RD_RESP:
        if (RREADY)
          nxt_st.rd_st = RD_IDLE;
      default:
        nxt_st.rd_st = RD_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; all masks come up selecting every channel
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_ff.rd_st    <= RD_IDLE;
      st_ff.aw_ok    <= 1'b0;
      st_ff.aw_idx   <= '0;
      st_ff.w_ok     <= 1'b0;
      st_ff.wdata    <= 32'h0000_0000;
      st_ff.wstrb    <= 4'h0;
      st_ff.bvalid   <= 1'b0;
      st_ff.bresp    <= RESP_OKAY;
      st_ff.ar_idx   <= '0;
      st_ff.rdata    <= 32'h0000_0000;
      st_ff.rresp    <= RESP_OKAY;
      st_ff.dac_sel  <= DAC_SEL_RST;
      st_ff.in_sel   <= IN_SEL_RST;
      st_ff.sld_en   <= SLD_EN_RST;
      st_ff.dac_bval <= BVAL_RST;
      st_ff.in_bval  <= BVAL_RST;
    end
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // channel code storage; direct holding writes use the caller's byte lanes, input broadcasts write both
  bwl_chan_bank #(
    .NCH (NCH),
    .DW  (DW)
  ) u_bank (
    .MCLK         (MCLK),
    .SYS_RST      (SYS_RST),
    .HOLD_WE      (hold_we),
    .HOLD_BE      (hold_be),
    .HOLD_WDATA   (hold_wdata),
    .ACT_WE       (act_we),
    .ACT_BE       (act_be),
    .ACT_WDATA    (act_wdata),
    .LOAD_MASK    (load_mask),
    .RD_ACTIVE    (rd_active),
    .RD_CH        (rd_ch),
    .RD_DATA      (bank_rd),
    .ACTIVE_CODES (CHANNEL_ACTIVE_CODE)
  );

endmodule

// [sim/bwl_regs_monitor.sv]
// port checker for the broadcast write and soft load register bank
`timescale 1ns/10ps
module bwl_regs_monitor
  import bwl_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int NCH    = 8,
  parameter int DW     = 16
)
(
  input wire logic              MCLK,
  input wire logic              SYS_RST,
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic              WVALID,
  input wire logic              WREADY,
  input wire logic [31:0]       WDATA,
  input wire logic              BVALID,
  input wire logic              BREADY,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic              RVALID,
  input wire logic              RREADY,
  input wire logic [31:0]       RDATA,
  input wire logic [NCH*DW-1:0] CHANNEL_ACTIVE_CODE
);
  logic [IDX_W-1:0]  aw_i_ff;
  logic [IDX_W-1:0]  ar_i_ff;
  logic [31:0]       wd_ff;
  logic [7:0]        dsel_ff;
  logic [7:0]        en_ff;
  logic [15:0]       ibv_ff;
  logic [NCH*DW-1:0] snap_ff;
  logic [NCH*DW-1:0] dmask;
  logic [NCH*DW-1:0] emask;
  logic              wr_end;

  // channel masks widened to the code bus
  always_comb
  begin
    for (int n = 0; n < NCH; n++)
    begin
      dmask[n*DW +: DW] = {DW{dsel_ff[n]}};
      emask[n*DW +: DW] = {DW{en_ff[n]}};
    end
  end
  assign wr_end = BVALID && BREADY;

  // shadows; codes snapped when the address lands, before any update
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      aw_i_ff <= '0;
      ar_i_ff <= '0;
      wd_ff   <= '0;
      dsel_ff <= DAC_SEL_RST;
      en_ff   <= SLD_EN_RST;
      ibv_ff  <= BVAL_RST;
      snap_ff <= '0;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_i_ff <= AWADDR[IDX_LSB +: IDX_W];
        snap_ff <= CHANNEL_ACTIVE_CODE;
      end
      if (WVALID && WREADY)
        wd_ff <= WDATA;
      if (ARVALID && ARREADY)
        ar_i_ff <= ARADDR[IDX_LSB +: IDX_W];
      if (wr_end && aw_i_ff == IDX_DAC_SEL)
        dsel_ff <= wd_ff[7:0];
      if (wr_end && aw_i_ff == IDX_SLD_EN)
        en_ff <= wd_ff[7:0];
      if (wr_end && aw_i_ff == IDX_IN_BVAL)
        ibv_ff <= wd_ff[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking mon_cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  sequence wr_at(logic [IDX_W-1:0] i);
    BVALID && BREADY && aw_i_ff == i;
  endsequence
  sequence rd_at(logic [IDX_W-1:0] i);
    RVALID && RREADY && ar_i_ff == i;
  endsequence

  chk_bcast_sel_hit: assert property (
    wr_at(IDX_DAC_BVAL) |->
      ((CHANNEL_ACTIVE_CODE ^ {NCH{wd_ff[DW-1:0]}}) & dmask) == '0)
    else $error("selected channel missed the broadcast value");
  chk_bcast_sel_miss: assert property (
    wr_at(IDX_DAC_BVAL) |-> ((CHANNEL_ACTIVE_CODE ^ snap_ff) & ~dmask) == '0)
    else $error("deselected channel changed on a broadcast");
  chk_trig_zero_idle: assert property (
    wr_at(IDX_TRIG) ##0 !wd_ff[TRIG_BIT] |-> CHANNEL_ACTIVE_CODE == snap_ff)
    else $error("trigger write of zero changed a channel");
  chk_trig_en_gate: assert property (
    wr_at(IDX_TRIG) |-> ((CHANNEL_ACTIVE_CODE ^ snap_ff) & ~emask) == '0)
    else $error("disabled channel loaded by the trigger");
  chk_trig_read_zero: assert property (
    rd_at(IDX_TRIG) |-> RDATA[7:0] == 8'h00)
    else $error("trigger register read not zero");
  chk_in_bval_back: assert property (
    rd_at(IDX_IN_BVAL) |-> RDATA[15:0] == ibv_ff)
    else $error("input broadcast value read back wrong");
  chk_dac_sel_back: assert property (
    rd_at(IDX_DAC_SEL) |-> RDATA[7:0] == dsel_ff)
    else $error("dac select mask read back wrong");
  chk_sld_en_back: assert property (
    rd_at(IDX_SLD_EN) |-> RDATA[7:0] == en_ff)
    else $error("soft load enable mask read back wrong");
endmodule

bind bwl_regs bwl_regs_monitor #(.ADDR_W(ADDR_W), .NCH(NCH), .DW(DW)) u_mon
  (.MCLK, .SYS_RST, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA,
   .BVALID, .BREADY, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA,
   .CHANNEL_ACTIVE_CODE);

// [sim/bwl_host.sv]
// behavioural axi4-lite host that walks the register map
`timescale 1ns/10ps
module bwl_host
  import bwl_pkg::*;
(
  input  wire logic        MCLK,
  output logic             AWVALID,
  input  wire logic        AWREADY,
  output logic      [9:0]  AWADDR,
  output logic      [2:0]  AWPROT,
  output logic             WVALID,
  input  wire logic        WREADY,
  output logic      [31:0] WDATA,
  output logic      [3:0]  WSTRB,
  input  wire logic        BVALID,
  output logic             BREADY,
  input  wire logic [1:0]  BRESP,
  output logic             ARVALID,
  input  wire logic        ARREADY,
  output logic      [9:0]  ARADDR,
  output logic      [2:0]  ARPROT,
  input  wire logic        RVALID,
  output logic             RREADY,
  input  wire logic [31:0] RDATA,
  input  wire logic [1:0]  RRESP
);
  // idle bus; payload lines are scrambled after use so stale data never helps
  initial
  begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, AWPROT, ARPROT} = 26'h0000000;
    WDATA = 32'h00000000;
    WSTRB = 4'hf;
  end

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] i, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    AWADDR  <= {i, 2'b00};
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    while (aw || w)
    begin
      @(posedge MCLK);
      aw = aw && !AWREADY;
      w = w && !WREADY;
      AWVALID <= aw;
      WVALID  <= w;
    end
    AWADDR <= ~AWADDR;
    WDATA  <= ~WDATA;
    do @(posedge MCLK); while (!BVALID);
    r = BRESP;
    BREADY <= 1'b0;
    @(posedge MCLK);
  endtask

  // read: address held until taken, then data held off until rvalid
  task automatic rd(input logic [7:0] i, output logic [31:0] d,
                    output logic [1:0] r);
    ARADDR  <= {i, 2'b00};
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do @(posedge MCLK); while (!ARREADY);
    ARVALID <= 1'b0;
    ARADDR  <= ~ARADDR;
    while (!RVALID)
      @(posedge MCLK);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    @(posedge MCLK);
  endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the broadcast write and soft load bank
`timescale 1ns/10ps
module tb
  import bwl_pkg::*;
;
  logic         MCLK;
  logic         SYS_RST;
  logic         AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic         ARVALID, ARREADY, RVALID, RREADY;
  logic [9:0]   AWADDR, ARADDR;
  logic [2:0]   AWPROT, ARPROT;
  logic [31:0]  WDATA, RDATA;
  logic [3:0]   WSTRB;
  logic [1:0]   BRESP, RRESP;
  logic [127:0] CHANNEL_ACTIVE_CODE;
  logic [15:0]  act [8] = '{default: 16'h0000};
  logic [15:0]  hold [8] = '{default: 16'h0000};
  int           n_fail = 0;
  int           checked = 0;
  int           cyc = 0;

  bwl_host host (.MCLK, .AWVALID, .AWREADY, .AWADDR, .AWPROT, .WVALID,
    .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY,
    .ARADDR, .ARPROT, .RVALID, .RREADY, .RDATA, .RRESP);
  bwl_regs dut (.MCLK, .SYS_RST, .AWVALID, .AWREADY, .AWADDR, .AWPROT,
    .WVALID, .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID,
    .ARREADY, .ARADDR, .ARPROT, .RVALID, .RREADY, .RDATA, .RRESP,
    .CHANNEL_ACTIVE_CODE);

  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [1:0] r;
    host.wr(i, d, r);
    cmp({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rchk(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd(i, d, r);
    cmp(d, e);
  endtask

  task automatic act_chk();
    for (int n = 0; n < 8; n++)
      cmp({16'h0000, CHANNEL_ACTIVE_CODE[n*16 +: 16]}, {16'h0000, act[n]});
  endtask

  task automatic hold_chk();
    for (int n = 0; n < 8; n++)
      rchk(IDX_HOLD_CH0 + 8'(2 * n), {16'h0000, hold[n]});
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(IDX_DAC_SEL, 32'h000000ff);
    rchk(IDX_SLD_EN, 32'h000000ff);
    rchk(IDX_IN_SEL, 32'h000000ff);
    rchk(IDX_TRIG, 32'h00000000);
    rchk(IDX_IN_BVAL, 32'h00000000);
  endtask

  // mixed mask so the deselected channels 0, 2, 5 and 7 stay put
  task automatic t_dac_bcast();
    wr(IDX_DAC_SEL, 32'h0000005a);
    rchk(IDX_DAC_SEL, 32'h0000005a);
    wr(IDX_DAC_BVAL, 32'h0000beef);
    for (int n = 0; n < 8; n++)
      if (n inside {1, 3, 4, 6})
        act[n] = 16'hbeef;
    act_chk();
    rchk(IDX_DAC_CH0 + 8'h02, 32'h0000beef);
    rchk(IDX_DAC_CH0, 32'h00000000);
    rchk(IDX_DAC_BVAL, 32'h0000beef);
    // a direct channel write must touch only its own channel
    wr(IDX_DAC_CH7, 32'h0000aaaa);
    act[7] = 16'haaaa;
    act_chk();
  endtask

  // second write with an empty mask must still be what reads back
  task automatic t_in_bcast();
    wr(IDX_IN_SEL, 32'h0000003c);
    wr(IDX_IN_BVAL, 32'h00001234);
    for (int n = 2; n < 6; n++)
      hold[n] = 16'h1234;
    rchk(IDX_IN_BVAL, 32'h00001234);
    hold_chk();
    wr(IDX_IN_SEL, 32'h00000000);
    wr(IDX_IN_BVAL, 32'h00007777);
    rchk(IDX_IN_BVAL, 32'h00007777);
    hold_chk();
  endtask

  // upper half enabled; zero and reserved-only writes come first
  task automatic t_soft_load();
    logic [31:0] d;
    logic [1:0]  r;
    wr(IDX_SLD_EN, 32'h000000f0);
    rchk(IDX_SLD_EN, 32'h000000f0);
    // a direct holding write gives channel 7 a value of its own to load
    wr(IDX_HOLD_CH7, 32'h00005a5a);
    hold[7] = 16'h5a5a;
    hold_chk();
    wr(IDX_TRIG, 32'h00000000);
    act_chk();
    wr(IDX_TRIG, 32'h0000007f);
    act_chk();
    rchk(IDX_TRIG, 32'h00000000);
    wr(IDX_TRIG, 32'h00000080);
    for (int n = 4; n < 8; n++)
      act[n] = hold[n];
    act_chk();
    rchk(IDX_TRIG, 32'h00000000);
    host.rd(8'h00, d, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  //////////////////////////////////////////////////////////////////////////
  // free-running clock, 4 ns period
  initial
  begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  initial
  begin
    SYS_RST = 1'b1;
    repeat (5) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    t_reset();
    t_dac_bcast();
    t_in_bcast();
    t_soft_load();
    give_verdict();
  end
endmodule
